/* File: rtl/ffh_fault_history.sv */
// fault summary flags and fault history stack with object dictionary access
// Notes on behaviour
// RULE1 - summary bit follows its fault, clears itself
// RULE2 - eight-bit read-only summary, bit six zero
// RULE3 - history holds eight 32-bit records
// RULE4 - new record enters first, older shift back
// RULE5 - sub-entry zero reports logged record count
// RULE6 - empty history refuses entry reads, abort 08000024h
// RULE7 - writing zero to count restarts history
// RULE8 - record: number, class, sixteen-bit code
// RULE9 - class byte equals summary at logging
// RULE10 - fault number encodes cause by fixed table
`timescale 1ns/1ns
`include "ffh_map.svh"
module ffh_fault_history
    import ffh_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int CAT = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [CAT-1:0] faultCond,
    input wire logic logEvent,
    input wire logic [7:0] logNumber,
    input wire logic [15:0] logCode,
    input wire logic odReqValid,
    input wire ffh_od_req_t odReq,
    output logic odRspValid,
    output ffh_od_rsp_t odRsp,
    output logic [7:0] faultSummary,
    output logic [7:0] historyCount
);

    // slot index width; a power-of-two depth keeps every select in range
    // deeper stacks also need a count that can reach the depth
    localparam int IW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    // summary path
    logic [CAT-1:0] condSync; // synchronised fault pins
    logic [7:0] next_faultSummary; // summary to be registered
    // logging path
    logic [7:0] riseBits; // categories that just appeared
    logic [7:0] pendingLog; // appeared categories not yet logged
    logic [7:0] servedBit; // category logged this cycle
    logic autoLog; // automatic record this cycle
    logic doLog; // any record this cycle
    logic [2:0] autoSel; // lowest pending category
    // stack path
    ffh_record_t newRecord; // record to push
    ffh_record_t histEntry [DEPTH]; // the history stack
    // count and dictionary path
    logic clearReq; // master writes zero to the count
    logic [7:0] next_historyCount; // count to be registered
    ffh_od_rsp_t next_odRsp; // answer to be registered
    logic [IW-1:0] entrySel; // stack slot addressed by a read
    logic subInStack; // sub-entry within one to depth

    ////////////////////////////////////////////////////////////////////////
    // cause table per category
    // unlisted categories use the generic internal cause
    function automatic logic [7:0] catNumber(input logic [2:0] cat);
        logic [7:0] num;
        num = `FFH_NUM_GENERIC;
        unique case (cat)
            3'(`FFH_BIT_CURRENT): num = `FFH_NUM_CURRENT;
            3'(`FFH_BIT_VOLTAGE): num = `FFH_NUM_VOLTAGE;
            3'(`FFH_BIT_TEMP): num = `FFH_NUM_TEMP;
            3'(`FFH_BIT_COMMS): num = `FFH_NUM_COMMS;
            default: num = `FFH_NUM_GENERIC; // general, profile, vendor
        endcase
        return num;
    endfunction : catNumber

    // fault code table per category
    function automatic logic [15:0] catCode(input logic [2:0] cat);
        logic [15:0] code;
        code = `FFH_CODE_GENERAL;
        unique case (cat)
            3'(`FFH_BIT_CURRENT): code = `FFH_CODE_CURRENT;
            3'(`FFH_BIT_VOLTAGE): code = `FFH_CODE_VOLTAGE;
            3'(`FFH_BIT_TEMP): code = `FFH_CODE_TEMP;
            3'(`FFH_BIT_COMMS): code = `FFH_CODE_COMMS;
            3'(`FFH_BIT_PROFILE): code = `FFH_CODE_PROFILE;
            3'(`FFH_BIT_VENDOR): code = `FFH_CODE_VENDOR;
            default: code = `FFH_CODE_GENERAL;
        endcase
        return code;
    endfunction : catCode

    ////////////////////////////////////////////////////////////////////////
    // fault pin synchroniser
    // only the pins come from outside the clock domain; logEvent and the
    // dictionary port come from logic on core_clk and pass no stages
    ffh_sync #(
        .WIDTH(CAT)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn(faultCond),
        .syncOut(condSync)
    );

    ////////////////////////////////////////////////////////////////////////
    // summary flags

    // flags mirror present faults; general covers every category
    // a pin change reaches the register five to six edges later
    // the reserved bit reads low whatever its pin shows
    always_comb begin
        // start from the pins, then fix reserved and general
        next_faultSummary = 8'(condSync); // see RULE1
        next_faultSummary[`FFH_BIT_RESERVED] = 1'b0; // see RULE2
        next_faultSummary[`FFH_BIT_GENERAL] = condSync[`FFH_BIT_GENERAL] | (|next_faultSummary[7:1]);
    end

    // summary register, cleared at reset
    // the master reads this value through the summary object
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            faultSummary <= `FFH_SUMMARY_RESET; // see RULE2
        end else begin
            faultSummary <= next_faultSummary; // see RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // automatic logging of newly raised categories
    // a rise is judged against the registered summary
    assign riseBits = next_faultSummary & ~faultSummary;

    // pick the lowest pending category above general
    // scanning downward leaves the lowest pending bit in autoSel
    always_comb begin
        autoSel = 3'h0;
        for (int i = CAT - 1; i > 0; i--) begin
            if (pendingLog[i]) begin // lower bits win
                autoSel = 3'(i);
            end
        end
    end

    // external event has priority over the automatic one
    // an external record holds the queue back by one cycle
    // servedBit retires the category logged at this edge
    assign autoLog = ~logEvent & (|pendingLog[7:1]);
    assign doLog = logEvent | autoLog;
    assign servedBit = autoLog ? (8'h01 << autoSel) : 8'h00;

    // pending set wins over the served clear
    // raised categories queue here and leave one per cycle
    // general never queues; it follows its own pin and the others
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pendingLog <= 8'h00;
        end else begin
            pendingLog <= ((pendingLog & ~servedBit) | riseBits) & 8'hFE;
        end
    end

    // assemble the record to push
    // class is the registered summary, so an automatic
    // record already carries its own category bit
    always_comb begin
        newRecord.faultClass = faultSummary; // see RULE9
        if (logEvent) begin // external cause
            newRecord.number = logNumber; // see RULE8
            newRecord.code = logCode; // see RULE8
        end else begin // automatic cause
            newRecord.number = catNumber(autoSel); // see RULE10
            newRecord.code = catCode(autoSel); // see RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // history stack
    // records move only on a push; reads never disturb them
    genvar s;
    generate
        for (s = 0; s < DEPTH; s++) begin : g_slot
            if (s == 0) begin : g_head
                // newest slot takes the new record
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        histEntry[s] <= `FFH_ENTRY_RESET; // see RULE3
                    end else if (doLog) begin
                        histEntry[s] <= newRecord; // see RULE4
                    end
                end
            end else begin : g_tail
                // older slots take their predecessor; the last falls out
                always_ff @(posedge core_clk or posedge rst) begin
                    if (rst) begin
                        histEntry[s] <= `FFH_ENTRY_RESET; // see RULE3
                    end else if (doLog) begin
                        histEntry[s] <= histEntry[s-1]; // see RULE4
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // record count
    assign clearReq = odReqValid & odReq.write & (odReq.index == `FFH_IDX_HISTORY)
                    & (odReq.sub == `FFH_SUB_COUNT) & (odReq.wdata == `FFH_CLEAR_VALUE);

    // count saturates at depth; a record in the clear cycle still counts
    // a clear restarts the count but leaves stored records in place;
    // reads above a nonzero count return whatever the slot still holds
    always_comb begin
        next_historyCount = historyCount;
        if (clearReq) begin // restart counting
            next_historyCount = `FFH_COUNT_RESET; // see RULE7
        end
        // log after clear, so a record in the clear cycle counts one
        if (doLog && next_historyCount < 8'(DEPTH)) begin
            next_historyCount = next_historyCount + 8'h01; // see RULE5
        end
    end

    // count register
    // the master reads this value at sub-entry zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            historyCount <= `FFH_COUNT_RESET;
        end else begin
            historyCount <= next_historyCount; // see RULE5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dictionary access
    assign subInStack = (odReq.sub >= `FFH_SUB_FIRST) && (odReq.sub <= 8'(DEPTH));
    assign entrySel = IW'(odReq.sub - `FFH_SUB_FIRST);

    // decode request into data or abort
    // decided from the request and the state before the taking edge
    // eight-bit objects answer in the low byte, upper bits zero
    always_comb begin
        next_odRsp.abort = 1'b0;
        next_odRsp.abortCode = `FFH_ABORT_NONE;
        next_odRsp.rdata = 32'h00000000;
        if (odReq.index == `FFH_IDX_SUMMARY) begin // summary object
            if (odReq.sub != `FFH_SUB_COUNT) begin // only sub zero exists
                next_odRsp.abort = 1'b1;
                next_odRsp.abortCode = `FFH_ABORT_NO_SUB;
            end else if (odReq.write) begin // read-only
                next_odRsp.abort = 1'b1;
                next_odRsp.abortCode = `FFH_ABORT_READ_ONLY; // see RULE2
            end else begin
                next_odRsp.rdata = {24'h000000, faultSummary}; // see RULE2
            end
        end else if (odReq.index == `FFH_IDX_HISTORY) begin // history object
            if (odReq.sub == `FFH_SUB_COUNT) begin // count sub-entry
                if (odReq.write && odReq.wdata != `FFH_CLEAR_VALUE) begin // only zero allowed
                    next_odRsp.abort = 1'b1;
                    next_odRsp.abortCode = `FFH_ABORT_BAD_VALUE; // see RULE7
                end else if (!odReq.write) begin
                    next_odRsp.rdata = {24'h000000, historyCount}; // see RULE5
                end
            end else if (subInStack) begin // record sub-entries
                if (odReq.write) begin // records are read-only
                    next_odRsp.abort = 1'b1;
                    next_odRsp.abortCode = `FFH_ABORT_READ_ONLY;
                end else if (historyCount == `FFH_COUNT_RESET) begin // empty stack
                    next_odRsp.abort = 1'b1;
                    next_odRsp.abortCode = `FFH_ABORT_EMPTY; // see RULE6
                end else begin
                    next_odRsp.rdata = histEntry[entrySel]; // see RULE3
                end
            end else begin // beyond depth
                next_odRsp.abort = 1'b1;
                next_odRsp.abortCode = `FFH_ABORT_NO_SUB;
            end
        end else begin // unknown object
            next_odRsp.abort = 1'b1;
            next_odRsp.abortCode = `FFH_ABORT_NO_OBJECT;
        end
    end

    // answer valid one cycle after each request
    // no back-pressure: every request is answered on the next edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            odRspValid <= 1'b0;
        end else begin
            odRspValid <= odReqValid;
        end
    end

    // answer data held until the next request
    // abort code and data stay readable between answers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            odRsp <= '0;
        end else if (odReqValid) begin
            odRsp <= next_odRsp;
        end
    end

endmodule : ffh_fault_history

/* File: rtl/ffh_map.svh */
// object dictionary addresses, field positions, reset values and code tables of the fault history block
`ifndef FFH_MAP_SVH
`define FFH_MAP_SVH

// object indices and sub-entries
`define FFH_IDX_SUMMARY 16'h1001
`define FFH_IDX_HISTORY 16'h1003
`define FFH_SUB_COUNT 8'h00
`define FFH_SUB_FIRST 8'h01

// summary bit positions
`define FFH_BIT_GENERAL 0
`define FFH_BIT_CURRENT 1
`define FFH_BIT_VOLTAGE 2
`define FFH_BIT_TEMP 3
`define FFH_BIT_COMMS 4
`define FFH_BIT_PROFILE 5
`define FFH_BIT_RESERVED 6
`define FFH_BIT_VENDOR 7

// reset values
`define FFH_SUMMARY_RESET 8'h00
`define FFH_COUNT_RESET 8'h00
`define FFH_ENTRY_RESET 32'h00000000
`define FFH_CLEAR_VALUE 32'h00000000

// abort codes of the dictionary answer
`define FFH_ABORT_NONE 32'h00000000
`define FFH_ABORT_EMPTY 32'h08000024
`define FFH_ABORT_NO_OBJECT 32'h06020000
`define FFH_ABORT_NO_SUB 32'h06090011
`define FFH_ABORT_READ_ONLY 32'h06010002
`define FFH_ABORT_BAD_VALUE 32'h06090030

// fault numbers used for automatic logging
`define FFH_NUM_WATCHDOG 8'h00
`define FFH_NUM_VOLTAGE 8'h01
`define FFH_NUM_CURRENT 8'h02
`define FFH_NUM_COMMS 8'h04
`define FFH_NUM_TEMP 8'h0C
`define FFH_NUM_GENERIC 8'h19

// fault codes used for automatic logging
`define FFH_CODE_GENERAL 16'h1000
`define FFH_CODE_CURRENT 16'h2300
`define FFH_CODE_VOLTAGE 16'h3000
`define FFH_CODE_TEMP 16'h4000
`define FFH_CODE_COMMS 16'h8100
`define FFH_CODE_PROFILE 16'hFF00
`define FFH_CODE_VENDOR 16'hFF01

`endif

/* File: rtl/ffh_pkg.sv */
// types shared by the fault history block
package ffh_pkg;

    // one history record: number, class, code
    typedef struct packed {
        logic [7:0] number;
        logic [7:0] faultClass;
        logic [15:0] code;
    } ffh_record_t;

    // dictionary access request
    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } ffh_od_req_t;

    // dictionary access answer
    typedef struct packed {
        logic abort;
        logic [31:0] abortCode;
        logic [31:0] rdata;
    } ffh_od_rsp_t;

endpackage : ffh_pkg

/* File: rtl/ffh_sync.sv */
// three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ns
module ffh_sync #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    ////////////////////////////////////////////////////////////////////////
    // per-bit stages
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            logic stage1; // metastable stage, read only by stage2
            logic stage2;
            logic stage3;

            // shift chain; output follows once stages two and three agree
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                    stage3 <= 1'b0;
                    syncOut[b] <= 1'b0;
                end else begin
                    stage1 <= asyncIn[b];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    if (stage2 == stage3) begin // stable level
                        syncOut[b] <= stage3;
                    end
                end
            end
        end
    endgenerate

endmodule : ffh_sync

/* File: sim/ffh_fault_history_sva.sv */
// port checker of the fault history block
`timescale 1ns/1ns
`include "ffh_map.svh"
module ffh_fault_history_sva
    import ffh_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int CAT = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [CAT-1:0] faultCond,
    input wire logic logEvent,
    input wire logic [7:0] logNumber,
    input wire logic [15:0] logCode,
    input wire logic odReqValid,
    input wire ffh_od_req_t odReq,
    input wire logic odRspValid,
    input wire ffh_od_rsp_t odRsp,
    input wire logic [7:0] faultSummary,
    input wire logic [7:0] historyCount
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // request decodes
    wire logic rdHist = odReqValid && !odReq.write && odReq.index == `FFH_IDX_HISTORY;
    wire logic rdSum = odReqValid && !odReq.write && odReq.index == `FFH_IDX_SUMMARY && odReq.sub == 8'h00;
    wire logic wrSum = odReqValid && odReq.write && odReq.index == `FFH_IDX_SUMMARY && odReq.sub == 8'h00;
    wire logic clrReq = odReqValid && odReq.write && odReq.index == `FFH_IDX_HISTORY && odReq.sub == 8'h00
        && odReq.wdata == 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    reserved_zero_a: assert property (faultSummary[6] == 1'b0)
        else $error("reserved summary bit set");
    general_flag_a: assert property (|faultSummary[7:1] |-> faultSummary[0])
        else $error("general flag missing");
    summary_set_a: assert property (faultCond[3] [*7] |-> faultSummary[3])
        else $error("summary bit not set");
    summary_clear_a: assert property (!faultCond[3] [*7] |-> !faultSummary[3])
        else $error("summary bit not cleared");
    empty_refuse_a: assert property (rdHist && odReq.sub inside {[8'h01:8'h08]} && historyCount == 8'h00
        |=> odRspValid && odRsp.abort && odRsp.abortCode == `FFH_ABORT_EMPTY)
        else $error("empty history read not refused");
    count_step_a: assert property (logEvent && historyCount < DEPTH && !clrReq
        |=> historyCount == $past(historyCount) + 8'h01) else $error("count did not step");
    count_clear_a: assert property (clrReq |=> historyCount <= 8'h01)
        else $error("count not restarted");
    count_limit_a: assert property (historyCount <= DEPTH) else $error("count above depth");
    summary_read_a: assert property (rdSum
        |=> odRspValid && !odRsp.abort && odRsp.rdata == {24'h000000, $past(faultSummary)})
        else $error("summary read wrong");
    ro_write_a: assert property (wrSum |=> odRsp.abort && odRsp.abortCode == `FFH_ABORT_READ_ONLY)
        else $error("summary write not refused");

    // main scenarios
    cover property (logEvent && historyCount == 8'h08);
    cover property (clrReq);
    cover property (rdSum);
endmodule : ffh_fault_history_sva

bind ffh_fault_history ffh_fault_history_sva #(.DEPTH(DEPTH), .CAT(CAT)) chk (.core_clk(core_clk), .rst(rst),
    .faultCond(faultCond), .logEvent(logEvent), .logNumber(logNumber), .logCode(logCode),
    .odReqValid(odReqValid), .odReq(odReq), .odRspValid(odRspValid), .odRsp(odRsp),
    .faultSummary(faultSummary), .historyCount(historyCount));

/* File: sim/ffh_master_model.sv */
// dictionary master model that issues requests to the fault history block
`timescale 1ns/1ns
module ffh_master_model
    import ffh_pkg::*;
(
    input wire logic core_clk,
    output logic odReqValid,
    output ffh_od_req_t odReq,
    input wire logic odRspValid,
    input wire ffh_od_rsp_t odRsp
);
    // idle request bus at time zero
    initial begin
        odReqValid = 1'b0;
        odReq = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one request held for a single edge; the answer is taken at the edge that shows it
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] wd, output ffh_od_rsp_t rsp);
        @(posedge core_clk);
        odReqValid <= 1'b1;
        odReq <= '{write: wr, index: idx, sub: sub, wdata: wd};
        @(posedge core_clk);
        odReqValid <= 1'b0;
        // released bus shows no stale request
        odReq <= ~odReq;
        // answer comes one cycle after the taking edge
        @(posedge core_clk);
        rsp = odRsp;
        // a missing answer pulse turns the abort flag to X so the check fails
        if (odRspValid !== 1'b1) begin
            rsp.abort = 1'bx;
        end
    endtask : access
endmodule : ffh_master_model

/* File: sim/tb_top.sv */
// self-checking bench of the fault history block
`timescale 1ns/1ns
`include "ffh_map.svh"
module tb_top
    import ffh_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] faultCond, logNumber, rn, fc;
    logic [15:0] logCode, rc;
    logic [23:0] cz;
    logic logEvent, odReqValid, odRspValid;
    ffh_od_req_t odReq;
    ffh_od_rsp_t odRsp, rsp;
    logic [7:0] faultSummary, historyCount;
    logic [31:0] expQ[$];
    int failures = 0, numChecks = 0, cycles = 0, i;
    integer seed = 32'h8BB38B16;

    always #5 core_clk = ~core_clk;

    ffh_fault_history dut (.core_clk(core_clk), .rst(rst), .faultCond(faultCond), .logEvent(logEvent),
        .logNumber(logNumber), .logCode(logCode), .odReqValid(odReqValid), .odReq(odReq),
        .odRspValid(odRspValid), .odRsp(odRsp), .faultSummary(faultSummary), .historyCount(historyCount));
    ffh_master_model mdl (.core_clk(core_clk), .odReqValid(odReqValid), .odReq(odReq),
        .odRspValid(odRspValid), .odRsp(odRsp));

    ////////////////////////////////////////////////////////////////////////////////
    // expected summary: reserved bit dropped, general flag from any category
    function automatic logic [7:0] sumOf(input logic [7:0] cond);
        logic [7:0] s;
        s = cond & 8'hBF;
        s[0] = |s;
        return s;
    endfunction : sumOf

    // expected cause number and code of an automatic record per category
    function automatic logic [23:0] causeOf(input int cat);
        case (cat)
            1: return 24'h022300; // current
            2: return 24'h013000; // voltage
            3: return 24'h0C4000; // temperature
            4: return 24'h048100; // communication
            5: return 24'h19FF00; // device profile
            default: return 24'h19FF01; // vendor
        endcase
    endfunction : causeOf

    // compare and count
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // single read through the master model
    task automatic rd(input logic [15:0] idx, input logic [7:0] sub);
        mdl.access(1'b0, idx, sub, 32'h00000000, rsp);
    endtask : rd

    // counts and verdict
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        faultCond = 8'h00;
        logEvent = 1'b0;
        logNumber = 8'h00;
        logCode = 16'h0000;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check({17'h00000, faultSummary, historyCount}, 33'h000000000);
        for (i = 1; i <= 8; i++) begin
            rd(`FFH_IDX_HISTORY, 8'(i));
            check({rsp.abort, rsp.abortCode}, {1'b1, 32'h08000024});
        end
        rd(16'h2000, 8'h00);
        check({rsp.abort, rsp.abortCode}, {1'b1, `FFH_ABORT_NO_OBJECT});
        mdl.access(1'b1, `FFH_IDX_SUMMARY, 8'h00, 32'h000000FF, rsp);
        check({rsp.abort, rsp.abortCode}, {1'b1, `FFH_ABORT_READ_ONLY});
        rd(`FFH_IDX_HISTORY, 8'h09);
        check({rsp.abort, rsp.abortCode}, {1'b1, `FFH_ABORT_NO_SUB});
        mdl.access(1'b1, `FFH_IDX_HISTORY, 8'h01, 32'h00000000, rsp);
        check({rsp.abort, rsp.abortCode}, {1'b1, `FFH_ABORT_READ_ONLY});
        mdl.access(1'b1, `FFH_IDX_HISTORY, 8'h00, 32'h00000005, rsp);
        check({rsp.abort, rsp.abortCode}, {1'b1, `FFH_ABORT_BAD_VALUE});
        check({25'h0000000, historyCount}, 33'h000000000);
        $display("test empty and refusals done");
        // temperature fault logs itself with the present summary
        @(posedge core_clk) faultCond <= 8'h48;
        repeat (10) @(posedge core_clk);
        check({25'h0000000, faultSummary}, {25'h0000000, sumOf(8'h48)});
        expQ.push_front({8'h0C, sumOf(8'h08), 16'h4000});
        rd(`FFH_IDX_HISTORY, 8'h01);
        check({rsp.abort, rsp.rdata}, {1'b0, expQ[0]});
        // back-to-back external records, corner values first
        for (i = 0; i < 10; i++) begin
            rn = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            rc = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
            @(posedge core_clk);
            logEvent <= 1'b1;
            logNumber <= rn;
            logCode <= rc;
            expQ.push_front({rn, sumOf(8'h08), rc});
        end
        @(posedge core_clk) logEvent <= 1'b0;
        while (expQ.size() > 8) begin
            void'(expQ.pop_back());
        end
        rd(`FFH_IDX_HISTORY, 8'h00);
        check({rsp.abort, rsp.rdata}, {1'b0, 32'h00000008});
        for (i = 1; i <= 8; i++) begin
            rd(`FFH_IDX_HISTORY, 8'(i));
            check({rsp.abort, rsp.rdata}, {1'b0, expQ[i-1]});
        end
        $display("test logging and stack done");
        // fault gone, summary clears by itself
        @(posedge core_clk) faultCond <= 8'h00;
        repeat (10) @(posedge core_clk);
        check({25'h0000000, faultSummary}, 33'h000000000);
        mdl.access(1'b1, `FFH_IDX_HISTORY, 8'h00, 32'h00000000, rsp);
        check({25'h0000000, historyCount}, 33'h000000000);
        rd(`FFH_IDX_HISTORY, 8'h01);
        check({rsp.abort, rsp.abortCode}, {1'b1, 32'h08000024});
        // one new record restarts counting at one
        @(posedge core_clk);
        logEvent <= 1'b1;
        logNumber <= 8'h19;
        logCode <= 16'hA5C3;
        @(posedge core_clk) logEvent <= 1'b0;
        rd(`FFH_IDX_HISTORY, 8'h01);
        check({rsp.abort, rsp.rdata}, {1'b0, 8'h19, 8'h00, 16'hA5C3});
        check({25'h0000000, historyCount}, 33'h000000001);
        $display("test clear and restart done");
        // random fault mix queues one record per raised category, lowest first
        expQ.delete();
        expQ.push_front({8'h19, 8'h00, 16'hA5C3});
        fc = 8'($random(seed)) | 8'h86;
        @(posedge core_clk) faultCond <= fc;
        repeat (16) @(posedge core_clk);
        check({25'h0000000, faultSummary}, {25'h0000000, sumOf(fc)});
        for (i = 1; i < 8; i++) begin
            cz = causeOf(i);
            if (fc[i] && i != 6) begin
                expQ.push_front({cz[23:16], sumOf(fc), cz[15:0]});
            end
        end
        rd(`FFH_IDX_HISTORY, 8'h00);
        check({rsp.abort, rsp.rdata}, {1'b0, 32'(expQ.size())});
        for (i = 1; i <= expQ.size(); i++) begin
            rd(`FFH_IDX_HISTORY, 8'(i));
            check({rsp.abort, rsp.rdata}, {1'b0, expQ[i-1]});
        end
        $display("test automatic logging done");
        end_of_test();
    end
endmodule : tb_top
